// >>> src/krc_cmd_unit.sv
// Command unit: presets, key load and store, random fill and soft reinit.
`timescale 1ns/1ps
`include "krc_defines.svh"
module krc_cmd_unit import krc_pkg::*; #(
    parameter int NUM_KEYS = 128,
    parameter int NVM_AW = 13,
    parameter logic [12:0] KEY_BASE = 13'h0c0,
    parameter logic [12:0] RX_PRESET_BASE = 13'h100,
    parameter logic [12:0] TX_PRESET_BASE = 13'h140,
    parameter logic [12:0] REG_DEFAULT_BASE = 13'h000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic host_we,
    input wire logic host_re,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic fifo_empty,
    input wire logic fifo_full,
    input wire logic [6:0] fifo_level,
    input wire logic [7:0] fifo_rdata,
    output logic fifo_pop,
    output logic fifo_push,
    output logic [7:0] fifo_wdata,
    output logic nvm_req,
    output logic nvm_we,
    output logic [NVM_AW-1:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic nvm_ack,
    input wire logic [7:0] nvm_rdata,
    input wire logic [7:0] rng_data,
    output logic cipher_key_we,
    output logic [2:0] cipher_key_byte,
    output logic [7:0] cipher_key_data,
    output krc_coding_t tx_coding,
    output logic [7:0] cmd_value
);
    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic krc_coding_t tx_coding_of(input logic [7:0] n);
        krc_coding_t c;
        c = KRC_COD_RESERVED;
        if (n <= 8'h03) c = KRC_COD_MILLER;
        else if (n <= 8'h07) c = KRC_COD_NRZ;
        else if (n <= 8'h09) c = KRC_COD_MANCH;
        else if (n <= 8'h0b) c = KRC_COD_1OF4;
        else if (n == 8'h0c) c = KRC_COD_1OF256;
        else if (n == 8'h0d) c = KRC_COD_UNITARY;
        else if (n < `KRC_TX_PRESET_LAST) c = KRC_COD_PIE;
        return c;
    endfunction

    function automatic logic key_ok(input logic [7:0] n);
        return ({24'h0, n} < NUM_KEYS);
    endfunction

    // ****************************************************************
    // Register file
    // ****************************************************************
    krc_state_t st_r, st_nxt;
    logic [7:0] val [`KRC_NUM_REGS];
    logic [7:0] rd [`KRC_NUM_REGS];
    logic [`KRC_NUM_REGS-1:0] int_we;
    logic [7:0] int_wd [`KRC_NUM_REGS];
    logic [7:0] ro_val [`KRC_NUM_REGS];
    logic busy;

    assign busy = (st_r != KRC_IDLE);

    generate
        for (genvar g = 0; g < `KRC_NUM_REGS; g++) begin : g_reg
            localparam logic [7:0] DY = (g == 0) ? `KRC_RW_MASK_COMMAND : (g == 2) ? 8'h03 :
                                        (g >= 6) ? 8'hff : 8'h00;
            localparam logic [7:0] RW = (g == 1) ? `KRC_RW_MASK_CTRL : 8'h00;
            localparam logic [7:0] WO = (g == 4) ? 8'hff : 8'h00;
            krc_reg_bits #(
                .RW_MASK(RW),
                .DY_MASK(DY),
                .WO_MASK(WO),
                .RST_VAL(8'h00)
            ) u_reg (
                .clk(clk),
                .reset(reset),
                .host_we(host_we && host_addr == 3'(g) && g != 5 && !(busy && g >= 6)),
                .host_wdata(host_wdata),
                .int_we(int_we[g]),
                .int_wdata(int_wd[g]),
                .ro_value(ro_val[g]),
                .value(val[g]),
                .host_rdata(rd[g])
            );
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < `KRC_NUM_REGS; i++) begin
            ro_val[i] = 8'h00;
        end
        ro_val[`KRC_REG_STATUS] = {5'h0, st_r};
    end

    assign host_rdata = host_re ? rd[host_addr] : 8'h00;
    assign cmd_value = val[`KRC_REG_COMMAND];
    assign tx_coding = tx_coding_of(val[`KRC_REG_TX]);

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] err_nxt;
    logic start;

    // A start is a write of a new code to the command register while idle.
    assign start = host_we && host_addr == `KRC_REG_COMMAND && !busy &&
                   (host_wdata & `KRC_CMD_MASK) != `KRC_CMD_IDLE;

    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        err_nxt = 8'h00;
        fifo_pop = 1'b0;
        fifo_push = 1'b0;
        fifo_wdata = rng_data;
        nvm_req = 1'b0;
        nvm_we = 1'b0;
        nvm_addr = '0;
        nvm_wdata = fifo_rdata;
        cipher_key_we = 1'b0;
        cipher_key_byte = cnt_r[2:0];
        cipher_key_data = nvm_rdata;
        int_we = '0;
        for (int i = 0; i < `KRC_NUM_REGS; i++) begin
            int_wd[i] = 8'h00;
        end
        case (st_r)
            KRC_IDLE: begin
                if (start) begin
                    cmd_nxt = host_wdata & `KRC_CMD_MASK;
                    cnt_nxt = 4'h0;
                    idx_nxt = 8'h00;
                    case (host_wdata & `KRC_CMD_MASK)
                        `KRC_CMD_PROTO, `KRC_CMD_LOADKEY, `KRC_CMD_STOREKEY: st_nxt = KRC_FETCH;
                        `KRC_CMD_RANDOM: st_nxt = KRC_RANDOM;
                        `KRC_CMD_REINIT: st_nxt = KRC_REINIT;
                        default: st_nxt = KRC_DONE;
                    endcase
                end
            end
            KRC_FETCH: begin
                // Parameters are checked before any pop so a short frame leaves the FIFO intact.
                if (cmd_r == `KRC_CMD_PROTO && fifo_level < 7'd2) begin
                    err_nxt[`KRC_ERR_ABORT_BIT] = 1'b1;
                    st_nxt = KRC_DONE;
                end else if (cmd_r == `KRC_CMD_LOADKEY && fifo_empty) begin
                    err_nxt[`KRC_ERR_ABORT_BIT] = 1'b1;
                    st_nxt = KRC_DONE;
                end else if (cmd_r == `KRC_CMD_STOREKEY && fifo_level < 7'd7) begin
                    err_nxt[`KRC_ERR_ABORT_BIT] = 1'b1;
                    st_nxt = KRC_DONE;
                end else if (cmd_r != `KRC_CMD_PROTO && !key_ok(fifo_rdata)) begin
                    fifo_pop = 1'b1;
                    err_nxt[`KRC_ERR_RANGE_BIT] = 1'b1;
                    st_nxt = KRC_DONE;
                end else begin
                    fifo_pop = 1'b1;
                    idx_nxt = fifo_rdata;
                    st_nxt = KRC_NVM;
                end
            end
            KRC_NVM: begin
                nvm_req = 1'b1;
                if (cmd_r == `KRC_CMD_STOREKEY) begin
                    nvm_we = 1'b1;
                    nvm_addr = KEY_BASE + NVM_AW'({idx_r, 3'h0}) + NVM_AW'(cnt_r);
                    if (nvm_ack) begin
                        fifo_pop = 1'b1;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == `KRC_KEY_BYTES - 4'h1) begin
                            cnt_nxt = 4'h0;
                            idx_nxt = idx_r + 8'h01;
                            // Keep going only with a whole key left; a stub stays queued.
                            if (fifo_level < 7'd7 || !key_ok(idx_r + 8'h01)) st_nxt = KRC_DONE;
                        end
                    end
                end else if (cmd_r == `KRC_CMD_LOADKEY) begin
                    nvm_addr = KEY_BASE + NVM_AW'({idx_r, 3'h0}) + NVM_AW'(cnt_r);
                    if (nvm_ack) begin
                        cipher_key_we = 1'b1;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == `KRC_KEY_BYTES - 4'h1) st_nxt = KRC_DONE;
                    end
                end else begin
                    // Preset load: first the receive byte from memory, then the transmit byte taken from the FIFO.
                    if (cnt_r == 4'h0) nvm_addr = RX_PRESET_BASE + NVM_AW'(idx_r);
                    else nvm_addr = TX_PRESET_BASE + NVM_AW'(fifo_rdata);
                    if (nvm_ack) begin
                        if (cnt_r == 4'h0) begin
                            int_we[`KRC_REG_RX] = 1'b1;
                            int_wd[`KRC_REG_RX] = nvm_rdata;
                            cnt_nxt = 4'h1;
                        end else begin
                            fifo_pop = 1'b1;
                            int_we[`KRC_REG_TX] = 1'b1;
                            int_wd[`KRC_REG_TX] = fifo_rdata;
                            st_nxt = KRC_DONE;
                        end
                    end
                end
            end
            KRC_RANDOM: begin
                if (fifo_full) begin
                    st_nxt = KRC_DONE;
                end else begin
                    fifo_push = 1'b1;
                end
            end
            KRC_REINIT: begin
                nvm_req = 1'b1;
                nvm_addr = REG_DEFAULT_BASE + NVM_AW'(idx_r);
                if (nvm_ack) begin
                    int_we[idx_r[2:0]] = 1'b1;
                    int_wd[idx_r[2:0]] = nvm_rdata;
                    idx_nxt = idx_r + 8'h01;
                    if (idx_r == 8'(`KRC_NUM_REGS - 1)) st_nxt = KRC_DONE;
                end
            end
            KRC_DONE: begin
                int_we[`KRC_REG_COMMAND] = 1'b1;
                int_wd[`KRC_REG_COMMAND] = `KRC_CMD_IDLE;
                st_nxt = KRC_IDLE;
            end
            default: st_nxt = KRC_IDLE;
        endcase
        // Writing the stop code aborts a running command at once.
        if (busy && st_r != KRC_DONE && host_we && host_addr == `KRC_REG_COMMAND &&
            (host_wdata & `KRC_CMD_STOP) != 8'h00) begin
            st_nxt = KRC_DONE;
        end
        if (err_nxt != 8'h00) begin
            int_we[`KRC_REG_ERROR] = 1'b1;
            int_wd[`KRC_REG_ERROR] = err_nxt;
        end else if (start) begin
            int_we[`KRC_REG_ERROR] = 1'b1;
            int_wd[`KRC_REG_ERROR] = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= KRC_IDLE;
            cmd_r <= 8'h00;
            idx_r <= 8'h00;
            cnt_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// >>> src/krc_defines.svh
// Constants of the key, random number and reset command unit.
`ifndef KRC_DEFINES_SVH
`define KRC_DEFINES_SVH
`define KRC_CMD_IDLE 8'h00
`define KRC_CMD_PROTO 8'h0d
`define KRC_CMD_LOADKEY 8'h0e
`define KRC_CMD_STOREKEY 8'h0f
`define KRC_CMD_RANDOM 8'h1c
`define KRC_CMD_REINIT 8'h1f
`define KRC_CMD_MASK 8'h1f
`define KRC_CMD_STOP 8'h80
`define KRC_KEY_BYTES 4'h6
`define KRC_TX_PRESET_LAST 8'h12
`define KRC_NUM_REGS 8
`define KRC_REG_COMMAND 3'h0
`define KRC_REG_CTRL 3'h1
`define KRC_REG_ERROR 3'h2
`define KRC_REG_STATUS 3'h3
`define KRC_REG_KEYCMD 3'h4
`define KRC_REG_RESERVED 3'h5
`define KRC_REG_RX 3'h6
`define KRC_REG_TX 3'h7
`define KRC_ERR_ABORT_BIT 0
`define KRC_ERR_RANGE_BIT 1
`define KRC_RW_MASK_CTRL 8'h7f
`define KRC_RW_MASK_COMMAND 8'h9f
`endif

// >>> src/krc_pkg.sv
// Types of the key, random number and reset command unit.
package krc_pkg;
    typedef enum logic [2:0] {
        KRC_IDLE,
        KRC_FETCH,
        KRC_NVM,
        KRC_RANDOM,
        KRC_REINIT,
        KRC_DONE
    } krc_state_t;

    typedef enum logic [2:0] {
        KRC_COD_MILLER,
        KRC_COD_NRZ,
        KRC_COD_MANCH,
        KRC_COD_1OF4,
        KRC_COD_1OF256,
        KRC_COD_UNITARY,
        KRC_COD_PIE,
        KRC_COD_RESERVED
    } krc_coding_t;
endpackage

// >>> src/krc_reg_bits.sv
// One host register with per-bit access classes.
`timescale 1ns/1ps
module krc_reg_bits #(
    parameter logic [7:0] RW_MASK = 8'hff,
    parameter logic [7:0] DY_MASK = 8'h00,
    parameter logic [7:0] WO_MASK = 8'h00,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic host_we,
    input wire logic [7:0] host_wdata,
    input wire logic int_we,
    input wire logic [7:0] int_wdata,
    input wire logic [7:0] ro_value,
    output logic [7:0] value,
    output logic [7:0] host_rdata
);
    logic [7:0] val_r;
    logic [7:0] val_nxt;

    always_comb begin
        val_nxt = val_r;
        if (host_we) begin
            val_nxt = (val_r & ~(RW_MASK | DY_MASK)) | (host_wdata & (RW_MASK | DY_MASK));
        end
        if (int_we) begin
            val_nxt = (val_nxt & ~DY_MASK) | (int_wdata & DY_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            val_r <= RST_VAL;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign value = val_r;
    assign host_rdata = ((val_r & (RW_MASK | DY_MASK)) | (ro_value & ~(RW_MASK | DY_MASK | WO_MASK)));
endmodule

// >>> bench/krc_cmd_unit_properties.sv
// Port checker of the command unit.
`timescale 1ns/1ps
`include "krc_defines.svh"
module krc_cmd_unit_properties #(
    parameter int NUM_KEYS = 128,
    parameter logic [12:0] KEY_BASE = 13'h0c0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic host_we,
    input wire logic host_re,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic fifo_empty,
    input wire logic fifo_full,
    input wire logic fifo_pop,
    input wire logic fifo_push,
    input wire logic [7:0] fifo_wdata,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [12:0] nvm_addr,
    input wire logic nvm_ack,
    input wire logic [7:0] nvm_rdata,
    input wire logic [7:0] rng_data,
    input wire logic cipher_key_we,
    input wire logic [2:0] cipher_key_byte,
    input wire logic [7:0] cipher_key_data,
    input wire logic [7:0] cmd_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    push_room_a: assert property (fifo_push |-> !fifo_full && fifo_wdata == rng_data)
        else $error("push into full fifo or wrong byte");
    pop_data_a: assert property (fifo_pop |-> !fifo_empty)
        else $error("pop from empty fifo");
    key_copy_a: assert property (cipher_key_we |-> nvm_ack && cipher_key_data == nvm_rdata && cipher_key_byte < 3'h6)
        else $error("cipher key byte not taken from memory");
    nvm_hold_a: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr) && $stable(nvm_we))
        else $error("memory request dropped early");
    // A write outside the key slots could destroy register defaults; the presets at 0x100 and 0x140 lie inside the key slot range.
    key_area_a: assert property (nvm_req && nvm_we |-> int'(nvm_addr) >= int'(KEY_BASE)
        && int'(nvm_addr) < int'(KEY_BASE) + 8 * NUM_KEYS && nvm_addr[2:0] < 3'h6)
        else $error("memory write outside key slots");
    cmd_start_a: assert property (host_we && host_addr == 3'h0 && !host_wdata[7] && host_wdata[4:0] != 5'h00
        && cmd_value == 8'h00 |=> cmd_value == {3'h0, $past(host_wdata[4:0])})
        else $error("command start not taken");
    fill_end_a: assert property (cmd_value == 8'h1c && fifo_full |-> ##[1:4] cmd_value == 8'h00)
        else $error("random fill did not end");
    idle_quiet_a: assert property (cmd_value == 8'h00 |-> !fifo_push && !cipher_key_we)
        else $error("activity while idle");
    wo_read_a: assert property (host_re && host_addr == `KRC_REG_KEYCMD |-> host_rdata == 8'h00)
        else $error("write-only register read nonzero");
    cover property (cipher_key_we && cipher_key_byte == 3'h5);
    cover property (nvm_req && nvm_we && nvm_ack);
    cover property (fifo_push && cmd_value == 8'h1c);
endmodule
bind krc_cmd_unit krc_cmd_unit_properties #(.NUM_KEYS(NUM_KEYS), .KEY_BASE(KEY_BASE)) u_props (
    .clk(clk), .reset(reset), .host_we(host_we), .host_re(host_re), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
    .fifo_pop(fifo_pop), .fifo_push(fifo_push), .fifo_wdata(fifo_wdata), .nvm_req(nvm_req),
    .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .rng_data(rng_data),
    .cipher_key_we(cipher_key_we), .cipher_key_byte(cipher_key_byte), .cipher_key_data(cipher_key_data),
    .cmd_value(cmd_value));

// >>> bench/krc_far_model.sv
// Far side model: parameter FIFO, nonvolatile memory and random source.
`timescale 1ns/1ps
module krc_far_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic fifo_pop,
    input wire logic fifo_push,
    input wire logic [7:0] fifo_wdata,
    output logic fifo_empty,
    output logic fifo_full,
    output logic [6:0] fifo_level,
    output logic [7:0] fifo_rdata,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [12:0] nvm_addr,
    input wire logic [7:0] nvm_wdata,
    output logic nvm_ack,
    output logic [7:0] nvm_rdata,
    output logic [7:0] rng_data,
    input wire logic tb_push,
    input wire logic [7:0] tb_data,
    input wire logic tb_flush,
    input wire logic [1:0] lat
);
    logic [7:0] fq [64];
    logic [7:0] mem [8192];
    logic [5:0] rp, wp;
    logic [1:0] wt;
    assign fifo_empty = fifo_level == 7'h00;
    assign fifo_full = fifo_level == 7'h40;
    // An empty FIFO shows a changing byte so that a stray pop never reads a plausible value.
    assign fifo_rdata = fifo_empty ? ~rng_data : fq[rp];
    initial for (int i = 0; i < 8192; i++) mem[i] = i[7:0] * 8'h1d + 8'(i[12:8]);
    always @(posedge clk) begin
        rng_data <= reset ? 8'h11 : rng_data + 8'h3b;
        if (reset || tb_flush) begin
            rp <= 6'h00;
            wp <= 6'h00;
            fifo_level <= 7'h00;
        end else begin
            rp <= rp + 6'(fifo_pop);
            if (fifo_push || tb_push) begin
                fq[wp] <= fifo_push ? fifo_wdata : tb_data;
                wp <= wp + 6'h01;
            end
            fifo_level <= fifo_level + 7'(fifo_push || tb_push) - 7'(fifo_pop);
        end
        nvm_ack <= 1'b0;
        nvm_rdata <= ~nvm_rdata;
        if (reset) begin
            wt <= 2'h0;
            nvm_rdata <= 8'h00;
        end else if (nvm_req && !nvm_ack) begin
            wt <= (wt == lat) ? 2'h0 : wt + 2'h1;
            if (wt == lat) begin
                nvm_ack <= 1'b1;
                nvm_rdata <= mem[nvm_addr];
                if (nvm_we) mem[nvm_addr] <= nvm_wdata;
            end
        end
    end
endmodule

// >>> bench/krc_cmd_unit_tb.sv
// Self-checking testbench of the command unit.
`timescale 1ns/1ps
`include "krc_defines.svh"
module krc_cmd_unit_tb import krc_pkg::*;;
    logic clk, reset = 1'b1, host_we = 1'b0, host_re = 1'b0, tb_push = 1'b0, tb_flush = 1'b0;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] host_wdata = 8'h00, tb_data = 8'h00, host_rdata, fifo_rdata, fifo_wdata, nvm_wdata;
    logic [7:0] nvm_rdata, rng_data, cipher_key_data, cmd_value, kcnt;
    logic [7:0] kb [6];
    logic [7:0] sb [15];
    logic [1:0] lat = 2'h0;
    logic fifo_empty, fifo_full, fifo_pop, fifo_push, nvm_req, nvm_we, nvm_ack, cipher_key_we;
    logic [6:0] fifo_level;
    logic [12:0] nvm_addr;
    logic [2:0] cipher_key_byte;
    krc_coding_t tx_coding;
    int n_fail = 0, num_checks = 0, n, seed_v;
    krc_cmd_unit u_dut (.clk(clk), .reset(reset), .host_we(host_we), .host_re(host_re), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
        .fifo_level(fifo_level), .fifo_rdata(fifo_rdata), .fifo_pop(fifo_pop), .fifo_push(fifo_push),
        .fifo_wdata(fifo_wdata), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .rng_data(rng_data), .cipher_key_we(cipher_key_we),
        .cipher_key_byte(cipher_key_byte), .cipher_key_data(cipher_key_data), .tx_coding(tx_coding),
        .cmd_value(cmd_value));
    krc_far_model u_far (.clk(clk), .reset(reset), .fifo_pop(fifo_pop), .fifo_push(fifo_push),
        .fifo_wdata(fifo_wdata), .fifo_empty(fifo_empty), .fifo_full(fifo_full), .fifo_level(fifo_level),
        .fifo_rdata(fifo_rdata), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .rng_data(rng_data), .tb_push(tb_push), .tb_data(tb_data),
        .tb_flush(tb_flush), .lat(lat));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] pat(int a);
        return a[7:0] * 8'h1d + 8'(a[12:8]);
    endfunction
    function automatic krc_coding_t cod(int t);
        return t < 4 ? KRC_COD_MILLER : t < 8 ? KRC_COD_NRZ : t < 10 ? KRC_COD_MANCH : t < 12 ? KRC_COD_1OF4 :
            t == 12 ? KRC_COD_1OF256 : t == 13 ? KRC_COD_UNITARY : t < 18 ? KRC_COD_PIE : KRC_COD_RESERVED;
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(negedge clk);
        host_we = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        host_we = 1'b0;
    endtask
    task automatic rdc(logic [2:0] a, logic [7:0] e, string nm);
        @(negedge clk);
        host_re = 1'b1;
        host_addr = a;
        #1 chk(nm, e, host_rdata);
        host_re = 1'b0;
    endtask
    task automatic push(logic [7:0] d);
        @(negedge clk);
        tb_push = 1'b1;
        tb_data = d;
        @(negedge clk);
        tb_push = 1'b0;
    endtask
    task automatic flush();
        @(negedge clk);
        tb_flush = 1'b1;
        @(negedge clk);
        tb_flush = 1'b0;
    endtask
    task automatic run(logic [7:0] c);
        kcnt = 8'h00;
        lat = 2'($urandom_range(0, 3));
        wr(3'h0, c);
        for (int i = 0; i < 3000 && cmd_value !== 8'h00; i++) @(negedge clk);
        chk("cmd_idle", 8'h00, cmd_value);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) if (cipher_key_we === 1'b1) begin
        kb[cipher_key_byte] <= cipher_key_data;
        kcnt <= kcnt + 8'h01;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed_v = $urandom(32'hcb05);
        repeat (16) @(negedge clk);
        reset = 1'b0;
        wr(3'h1, 8'h55);
        wr(3'h4, 8'hff);
        rdc(3'h4, 8'h00, "wo_read");
        wr(3'h3, 8'hff);
        rdc(3'h3, 8'h00, "ro_status");
        for (int k = 0; k < 3; k++) begin
            n = k == 0 ? 0 : k == 1 ? 127 : $urandom_range(1, 126);
            push(8'(n));
            run(`KRC_CMD_LOADKEY);
            chk("key_count", 8'h06, kcnt);
            for (int b = 0; b < 6; b++) chk("key_byte", pat(32'h0c0 + n * 8 + b), kb[b]);
            rdc(3'h2, 8'h00, "ld_err");
        end
        push(8'h80);
        run(`KRC_CMD_LOADKEY);
        rdc(3'h2, 8'h02, "ld_range");
        run(`KRC_CMD_LOADKEY);
        rdc(3'h2, 8'h01, "ld_miss");
        chk("ld_none", 8'h00, kcnt);
        for (int i = 0; i < 7; i++) push(i == 0 ? 8'h80 : 8'h11);
        run(`KRC_CMD_STOREKEY);
        rdc(3'h2, 8'h02, "st_range");
        flush();
        for (int i = 0; i < 4; i++) push(8'h05);
        run(`KRC_CMD_STOREKEY);
        rdc(3'h2, 8'h01, "st_miss");
        flush();
        n = $urandom_range(0, 125);
        push(8'(n));
        for (int j = 0; j < 15; j++) begin
            sb[j] = 8'($urandom);
            push(sb[j]);
        end
        run(`KRC_CMD_STOREKEY);
        chk("st_tail", 8'h03, {1'b0, fifo_level});
        for (int j = 0; j < 12; j++) chk("st_byte", sb[j], u_far.mem[32'h0c0 + (n + j / 6) * 8 + j % 6]);
        chk("st_next", pat(32'h0c0 + (n + 2) * 8), u_far.mem[32'h0c0 + (n + 2) * 8]);
        flush();
        for (int i = 0; i < 5; i++) push(8'($urandom));
        run(`KRC_CMD_RANDOM);
        chk("rng_level", 8'h40, {1'b0, fifo_level});
        flush();
        wr(3'h0, `KRC_CMD_RANDOM);
        wr(3'h0, `KRC_CMD_STOP);
        repeat (4) @(negedge clk);
        chk("stop_idle", 8'h00, cmd_value);
        chk("stop_full", 8'h00, {7'h00, fifo_full});
        flush();
        for (int t = 0; t < 19; t++) begin
            n = $urandom_range(0, 17);
            push(8'(n));
            push(8'(t));
            run(`KRC_CMD_PROTO);
            rdc(3'h6, u_far.mem[32'h100 + n], "rx_preset");
            rdc(3'h7, 8'(t), "tx_preset");
            chk("tx_coding", {5'h00, cod(t)}, {5'h00, tx_coding});
        end
        rdc(3'h1, 8'h55, "rw_kept");
        // The reloaded command byte must stay nonzero, or the wait would end before the last register loads.
        u_far.mem[0] = `KRC_CMD_REINIT;
        u_far.mem[6] = 8'h3c;
        u_far.mem[7] = 8'h04;
        run(`KRC_CMD_REINIT);
        rdc(3'h6, 8'h3c, "reinit_rx");
        chk("reinit_tx", {5'h00, KRC_COD_NRZ}, {5'h00, tx_coding});
        give_verdict();
    end
endmodule
